/* rtl/brake_seq_pkg.sv */
package brake_seq_pkg;

   // register bus shape
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int CFG_N  = 8;

   // register indices
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_MAG       = 4'h1;
   localparam logic [3:0] REG_OPEN      = 4'h2;
   localparam logic [3:0] REG_CLOSE     = 4'h3;
   localparam logic [3:0] REG_OUT0_SEL  = 4'h4;
   localparam logic [3:0] REG_OUT1_SEL  = 4'h5;
   localparam logic [3:0] REG_POWER     = 4'h6;
   localparam logic [3:0] REG_COAST_SEL = 4'h7;
   localparam logic [3:0] REG_STATUS    = 4'h8;

   // field positions
   localparam int CTRL_ENABLE_BIT   = 0;
   localparam int COAST_IDX_LSB     = 0;
   localparam int COAST_IDX_W       = 4;
   localparam int COAST_GRP_LSB     = 4;
   localparam int STAT_STATE_LSB    = 0;
   localparam int STAT_BRAKE_BIT    = 4;
   localparam int STAT_ENERGIZE_BIT = 5;
   localparam int STAT_CHOPPER_BIT  = 6;
   localparam int STAT_EXTEND_BIT   = 7;

   // reset values, index 7 first; delays in ms, power in 0.01 kW
   localparam logic [CFG_N-1:0][DATA_W-1:0] CFG_RESET = {
      16'h0000,   // coast_stop_source_select: none
      16'h0000,   // resistor_braking_power: 0 kW
      16'h0000,   // output_one_source_select
      16'h0000,   // output_zero_source_select
      16'h0064,   // brake_close_delay: 100 ms
      16'h0064,   // brake_open_delay: 100 ms
      16'h0000,   // magnetize_interval: 0 ms
      16'h0000};  // control: holding_brake_enable off

   // source codes
   localparam logic [15:0] SRC_BRAKE_RELEASE = 16'h145c; // 52.12
   localparam logic [11:0] COAST_GRP_DIGIN   = 12'h2d2;  // 722.x

   // thresholds
   localparam logic [15:0] STOP_SPEED_RPM    = 16'h0014;
   localparam logic [15:0] DCLINK_MAX_LEVEL  = 16'h0320;
   localparam logic [15:0] CHOP_HYST_LEVEL   = 16'h0014;
   localparam logic [15:0] RAMP_EXTEND_POWER = 16'h000a;

   // timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int TICK_TIME_MS  = 1;
   localparam int CYCLES_PER_MS = CLK_HZ / 1000 * TICK_TIME_MS;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_MAGNETIZE = 3'b001,
      ST_OPENING   = 3'b011,
      ST_RUN       = 3'b010,
      ST_RAMPDOWN  = 3'b110,
      ST_CLOSING   = 3'b111
   } seq_state_e;

   typedef struct packed {
      logic switch_on;
      logic ramp_stop;
      logic quick_stop;
      logic coast_stop;
   } cmd_s;

   typedef struct packed {
      logic energize;
      logic brake_release;
      logic hold_zero;
      logic accel;
      logic ramp_down;
      logic quick;
   } drive_s;

endpackage : brake_seq_pkg

/* rtl/chopper_ctrl.sv */
`timescale 1ns/1ns
module chopper_ctrl
   import brake_seq_pkg::*;
#(
   parameter logic [15:0] ON_LEVEL   = DCLINK_MAX_LEVEL,
   parameter logic [15:0] HYST_LEVEL = CHOP_HYST_LEVEL
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        enable_i,
   input  wire logic [15:0] dclink_i,
   output logic             chop_o
);
   logic next_chop;

   // hysteresis keeps the chopper from chattering around the limit
   always_comb begin
      next_chop = chop_o;
      if (!enable_i) begin
         next_chop = 1'b0;
      end else if (dclink_i >= ON_LEVEL) begin
         next_chop = 1'b1;
      end else if (dclink_i < ON_LEVEL - HYST_LEVEL) begin
         next_chop = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         chop_o <= 1'b0;
      end else begin
         chop_o <= next_chop;
      end
   end

   property p_chop_on;
      @(posedge core_clk_i) disable iff (rst_i)
      enable_i && dclink_i >= ON_LEVEL |=> chop_o;
   endproperty
   a_chop_on: assert property (p_chop_on)
      else $error("chopper off above dc-link limit");

endmodule : chopper_ctrl

/* rtl/motor_brake_sequencer.sv */
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module motor_brake_sequencer
   import brake_seq_pkg::*;
#(
   parameter int DIGIN_N        = 16,
   parameter int TICK_CYCLES    = CYCLES_PER_MS
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic              switch_on_i,
   input  wire logic              ramp_stop_i,
   input  wire logic              quick_stop_i,
   input  wire logic              coast_stop_i,
   input  wire logic [DIGIN_N-1:0] dig_in_i,
   input  wire logic [15:0]       actual_speed_i,
   input  wire logic [15:0]       dclink_voltage_i,
   output logic                   brake_release_o,
   output logic [1:0]             dig_out_o,
   output logic                   motor_energize_o,
   output logic                   hold_zero_speed_o,
   output logic                   accel_enable_o,
   output logic                   ramp_down_o,
   output logic                   quick_stop_active_o,
   output logic                   chopper_on_o,
   output logic                   ovlim_enable_o,
   output logic                   ramp_extend_o
);
   cmd_s                           cmd_meta;
   cmd_s                           cmd_sync;
   logic [DIGIN_N-1:0]             dig_meta;
   logic [DIGIN_N-1:0]             dig_sync;
   logic [CFG_N-1:0][DATA_W-1:0]   cfg;
   logic [CFG_N-1:0][DATA_W-1:0]   next_cfg;
   logic [DATA_W-1:0]              next_rdata;
   seq_state_e                     state;
   seq_state_e                     next_state;
   drive_s                         next_drive;
   logic [1:0]                     next_dig_out;
   logic [15:0]                    ms_cnt;
   logic [15:0]                    next_ms_cnt;
   logic                           tick;
   logic                           timer_load;
   logic [15:0]                    timer_count;
   logic                           timer_done;
   logic                           brake_en;
   logic                           dig_coast;
   logic                           coast;
   logic                           stop_req;
   logic                           below_stop;
   logic [11:0]                    coast_grp;
   logic [COAST_IDX_W-1:0]         coast_idx;
   logic [DATA_W-1:0]              power;
   logic                           chop_next;
   default clocking cb_core @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // pin commands pass two flops before anything looks at them
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cmd_meta <= '0;
         cmd_sync <= '0;
         dig_meta <= '1;
         dig_sync <= '1;
      end else begin
         cmd_meta <= cmd_s'{switch_on_i, ramp_stop_i, quick_stop_i,
                            coast_stop_i};
         cmd_sync <= cmd_meta;
         dig_meta <= dig_in_i;
         dig_sync <= dig_meta;
      end
   end
   // configuration fields in use
   assign brake_en   = cfg[REG_CTRL[2:0]][CTRL_ENABLE_BIT];
   assign power      = cfg[REG_POWER[2:0]];
   assign coast_grp  = cfg[REG_COAST_SEL[2:0]][COAST_GRP_LSB +: 12];
   assign coast_idx  = cfg[REG_COAST_SEL[2:0]][COAST_IDX_LSB +: COAST_IDX_W];
   // selected input low means resistor overtemperature contact opened
   assign dig_coast  = (coast_grp == COAST_GRP_DIGIN) &&
                       !dig_sync[coast_idx];
   assign coast      = cmd_sync.coast_stop || dig_coast;
   assign stop_req   = cmd_sync.ramp_stop || cmd_sync.quick_stop;
   assign below_stop = actual_speed_i < STOP_SPEED_RPM;
   // register writes and read mux; reads answer one cycle later only
   always_comb begin
      next_cfg   = cfg;
      next_rdata = '0;
      if (wr_i && !addr_i[3]) begin
         next_cfg[addr_i[2:0]] = wdata_i;
      end
      if (rd_i) begin
         if (!addr_i[3]) begin
            next_rdata = cfg[addr_i[2:0]];
         end else if (addr_i == REG_STATUS) begin
            next_rdata[STAT_STATE_LSB +: 3]  = state;
            next_rdata[STAT_BRAKE_BIT]       = brake_release_o;
            next_rdata[STAT_ENERGIZE_BIT]    = motor_energize_o;
            next_rdata[STAT_CHOPPER_BIT]     = chopper_on_o;
            next_rdata[STAT_EXTEND_BIT]      = ramp_extend_o;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg     <= CFG_RESET;
         rdata_o <= '0;
      end else begin
         cfg     <= next_cfg;
         rdata_o <= next_rdata;
      end
   end
   // ms prescaler; restarted at each load so no delay comes out short
   assign tick = (ms_cnt == 16'(TICK_CYCLES - 1));
   always_comb begin
      next_ms_cnt = ms_cnt + 16'h0001;
      if (timer_load || tick) begin
         next_ms_cnt = '0;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ms_cnt <= '0;
      end else begin
         ms_cnt <= next_ms_cnt;
      end
   end
   // brake sequence; coast stop overrides everything else
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cmd_sync.switch_on && !stop_req && !coast) begin
               next_state = ST_MAGNETIZE;
            end
         end
         ST_MAGNETIZE: begin
            if (coast || stop_req) begin
               next_state = ST_IDLE;
            end else if (timer_done) begin
               // with the brake function off, no release is sequenced
               next_state = brake_en ? ST_OPENING : ST_RUN;
            end
         end
         ST_OPENING: begin
            if (coast) begin
               next_state = ST_IDLE;
            end else if (stop_req) begin
               next_state = ST_RAMPDOWN;
            end else if (timer_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (coast) begin
               next_state = ST_IDLE;
            end else if (stop_req) begin
               next_state = ST_RAMPDOWN;
            end
         end
         ST_RAMPDOWN: begin
            if (coast) begin
               next_state = ST_IDLE;
            end else if (below_stop) begin
               next_state = brake_en ? ST_CLOSING : ST_IDLE;
            end else if (!stop_req && cmd_sync.switch_on) begin
               next_state = ST_RUN;
            end
         end
         ST_CLOSING: begin
            if (coast || timer_done) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end
   // load the shared delay counter on entry to each timed state
   always_comb begin
      timer_load  = (next_state != state);
      timer_count = '0;
      case (next_state)
         ST_MAGNETIZE: timer_count = cfg[REG_MAG[2:0]];
         ST_OPENING:   timer_count = cfg[REG_OPEN[2:0]];
         ST_CLOSING:   timer_count = cfg[REG_CLOSE[2:0]];
         default:      timer_count = '0;
      endcase
   end
   seq_delay_timer #(
      .W       (16)
   ) u_timer (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .tick_i     (tick),
      .load_i     (timer_load),
      .count_i    (timer_count),
      .done_o     (timer_done)
   );
   chopper_ctrl u_chopper (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .enable_i   (power != '0),
      .dclink_i   (dclink_voltage_i),
      .chop_o     (chop_next)
   );
   // drive outputs decoded from the next state so they align with state
   always_comb begin
      next_drive               = '0;
      next_drive.energize      = (next_state != ST_IDLE);
      next_drive.brake_release = brake_en &&
         (next_state == ST_OPENING || next_state == ST_RUN ||
          next_state == ST_RAMPDOWN);
      next_drive.hold_zero     = (next_state == ST_MAGNETIZE ||
         next_state == ST_OPENING || next_state == ST_CLOSING);
      next_drive.accel         = (next_state == ST_RUN);
      next_drive.ramp_down     = (next_state == ST_RAMPDOWN);
      next_drive.quick         = (next_state == ST_RAMPDOWN) &&
                                 cmd_sync.quick_stop;
   end
   // per-output routing of the brake command
   for (genvar k = 0; k < 2; k++) begin : g_dout
      assign next_dig_out[k] = next_drive.brake_release &&
         (cfg[REG_OUT0_SEL[2:0] + 3'(k)] == SRC_BRAKE_RELEASE);
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state               <= ST_IDLE;
         brake_release_o     <= 1'b0;
         dig_out_o           <= '0;
         motor_energize_o    <= 1'b0;
         hold_zero_speed_o   <= 1'b0;
         accel_enable_o      <= 1'b0;
         ramp_down_o         <= 1'b0;
         quick_stop_active_o <= 1'b0;
         chopper_on_o        <= 1'b0;
         ovlim_enable_o      <= 1'b1;
         ramp_extend_o       <= 1'b0;
      end else begin
         state               <= next_state;
         brake_release_o     <= next_drive.brake_release;
         dig_out_o           <= next_dig_out;
         motor_energize_o    <= next_drive.energize;
         hold_zero_speed_o   <= next_drive.hold_zero;
         accel_enable_o      <= next_drive.accel;
         ramp_down_o         <= next_drive.ramp_down;
         quick_stop_active_o <= next_drive.quick;
         chopper_on_o        <= chop_next;
         ovlim_enable_o      <= (power == '0);
         ramp_extend_o       <= (power != '0) &&
                                (power < RAMP_EXTEND_POWER);
      end
   end
   property p_release_after_mag;
      $rose(brake_release_o) |-> $past(state) == ST_MAGNETIZE;
   endproperty
   a_release_after_mag: assert property (p_release_after_mag)
      else $error("brake released without magnetizing first");
   property p_mag_done_opens;
      state == ST_MAGNETIZE && timer_done && brake_en && !coast && !stop_req
      |=> brake_release_o && state == ST_OPENING;
   endproperty
   a_mag_done_opens: assert property (p_mag_done_opens)
      else $error("no brake release after magnetize interval");
   property p_opening_holds;
      state == ST_OPENING |-> hold_zero_speed_o && !accel_enable_o;
   endproperty
   a_opening_holds: assert property (p_opening_holds)
      else $error("acceleration during brake opening delay");
   property p_accel_after_open;
      $rose(accel_enable_o) && brake_en && $past(state) != ST_RAMPDOWN |->
         $past(state) == ST_OPENING && $past(timer_done);
   endproperty
   a_accel_after_open: assert property (p_accel_after_open)
      else $error("acceleration before opening delay expired");
   property p_rampdown_released;
      state == ST_RAMPDOWN && $past(brake_en) |->
         brake_release_o && ramp_down_o;
   endproperty
   a_rampdown_released: assert property (p_rampdown_released)
      else $error("brake not released during ramp stop");
   property p_slow_closes;
      state == ST_RAMPDOWN && below_stop && brake_en && !coast
      |=> state == ST_CLOSING && !brake_release_o && motor_energize_o;
   endproperty
   a_slow_closes: assert property (p_slow_closes)
      else $error("brake not closed below stop speed");
   property p_closing_energized;
      state == ST_CLOSING && !timer_done && !coast |=> motor_energize_o;
   endproperty
   a_closing_energized: assert property (p_closing_energized)
      else $error("motor off before brake close delay");
   property p_coast_drops;
      coast |=> !brake_release_o && !motor_energize_o;
   endproperty
   a_coast_drops: assert property (p_coast_drops)
      else $error("brake release held after coast stop");
   property p_route_out0;
      dig_out_o[0] == (brake_release_o &&
         $past(cfg[REG_OUT0_SEL[2:0]]) == SRC_BRAKE_RELEASE);
   endproperty
   a_route_out0: assert property (p_route_out0)
      else $error("output zero does not follow brake release");
   property p_ovlim_off;
      power != '0 |=> !ovlim_enable_o;
   endproperty
   a_ovlim_off: assert property (p_ovlim_off)
      else $error("overvoltage limiter active with resistor power");
   property p_disabled_no_release;
      !brake_en |=> !brake_release_o;
   endproperty
   a_disabled_no_release: assert property (p_disabled_no_release)
      else $error("brake release while function disabled");

endmodule : motor_brake_sequencer

/* rtl/seq_delay_timer.sv */
`timescale 1ns/1ns
module seq_delay_timer
   import brake_seq_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic         tick_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output logic              done_o
);
   logic [W-1:0] remaining;
   logic [W-1:0] next_remaining;

   // reload on sequence entry, then count down one per ms tick
   always_comb begin
      next_remaining = remaining;
      if (load_i) begin
         next_remaining = count_i;
      end else if (tick_i && remaining != '0) begin
         next_remaining = remaining - W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         remaining <= '0;
      end else begin
         remaining <= next_remaining;
      end
   end

   assign done_o = (remaining == '0);

   property p_reload;
      @(posedge core_clk_i) disable iff (rst_i)
      load_i |=> remaining == $past(count_i);
   endproperty
   a_reload: assert property (p_reload)
      else $error("timer did not reload on entry");

endmodule : seq_delay_timer

/* test/brake_relay_model.sv */
`timescale 1ns/1ns
// interface relay plus brake lining: it moves only after its travel time
module brake_relay_model #(
   parameter int OPEN_CYC  = 3,
   parameter int CLOSE_CYC = 2
) (
   input  wire logic core_clk_i,
   input  wire logic coil_i,
   output logic      brake_open_o
);
   int cnt = 0;
   initial brake_open_o = 1'b0;
   // a coil change mid-travel restarts the travel, as a real lining would
   always @(posedge core_clk_i) begin
      if (coil_i === brake_open_o) begin
         cnt <= 0;
      end else if (cnt + 1 >= (coil_i ? OPEN_CYC : CLOSE_CYC)) begin
         brake_open_o <= coil_i;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : brake_relay_model

/* test/motor_brake_sequencer_tb.sv */
`timescale 1ns/1ns
module motor_brake_sequencer_tb;
   import brake_seq_pkg::*;
   localparam int TICK = 4;
   localparam int BRK = 0, ENG = 1, ACC = 3, RMP = 4, CHP = 6;
   logic              core_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   cmd_s              cmd = '0;
   logic [15:0]       dig_in = 16'hffff;
   logic [15:0]       speed = 16'h01f4;
   logic [15:0]       dclink = 16'h0200;
   logic [DATA_W-1:0] rdata_o;
   logic [1:0]        dig_out_o;
   logic brake_release_o, motor_energize_o, hold_zero_speed_o;
   logic accel_enable_o, ramp_down_o, quick_stop_active_o;
   logic chopper_on_o, ovlim_enable_o, ramp_extend_o, brake_open;
   int bad_count = 0;
   int samples_checked = 0;
   int n;
   wire [7:0] obs = {ramp_extend_o, chopper_on_o, quick_stop_active_o,
      ramp_down_o, accel_enable_o, hold_zero_speed_o, motor_energize_o,
      brake_release_o};

   motor_brake_sequencer #(.DIGIN_N(16), .TICK_CYCLES(TICK)) uut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .switch_on_i(cmd.switch_on), .ramp_stop_i(cmd.ramp_stop),
      .quick_stop_i(cmd.quick_stop), .coast_stop_i(cmd.coast_stop),
      .dig_in_i(dig_in), .actual_speed_i(speed), .dclink_voltage_i(dclink),
      .brake_release_o(brake_release_o), .dig_out_o(dig_out_o),
      .motor_energize_o(motor_energize_o),
      .hold_zero_speed_o(hold_zero_speed_o),
      .accel_enable_o(accel_enable_o), .ramp_down_o(ramp_down_o),
      .quick_stop_active_o(quick_stop_active_o),
      .chopper_on_o(chopper_on_o), .ovlim_enable_o(ovlim_enable_o),
      .ramp_extend_o(ramp_extend_o));

   brake_relay_model #(.OPEN_CYC(3), .CLOSE_CYC(2)) relay (
      .core_clk_i(core_clk_i), .coil_i(dig_out_o[0]),
      .brake_open_o(brake_open));

   // free-running core clock
   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end

   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe edge
   task automatic rd(logic [3:0] a, logic [15:0] exp, string name);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 chk(name, exp, rdata_o);
   endtask : rd

   // counts edges until an output reaches a level; bounded so a hang shows
   task automatic wait_bit(int k, logic v, output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk_i);
         #1 cnt++;
      end while (obs[k] !== v && cnt < 3000);
      if (obs[k] !== v) chk("wait on output", 16'(v), 16'(obs[k]));
   endtask : wait_bit

   task automatic stop_cycle(logic quick);
      @(posedge core_clk_i);
      cmd.switch_on <= 1'b1;
      speed <= 16'h01f4;
      wait_bit(ENG, 1'b1, n);
      chk("brake while magnetizing", 0, brake_release_o);
      wait_bit(BRK, 1'b1, n);
      chk("magnetize cycles", 2 * TICK + 1, n);
      chk("output zero", 2'b01, dig_out_o);
      chk("hold at opening", 1, hold_zero_speed_o);
      wait_bit(ACC, 1'b1, n);
      chk("opening cycles", TICK + 1, n);
      chk("brake lifted", 1, brake_open);
      @(posedge core_clk_i);
      cmd.switch_on <= 1'b0;
      if (quick) cmd.quick_stop <= 1'b1;
      else cmd.ramp_stop <= 1'b1;
      wait_bit(RMP, 1'b1, n);
      chk("brake in rampdown", 1, brake_release_o);
      chk("quick flag", 16'(quick), quick_stop_active_o);
      @(posedge core_clk_i) speed <= 16'h0014;
      repeat (4) @(posedge core_clk_i);
      #1 chk("brake at 20 rpm", 1, brake_release_o);
      @(posedge core_clk_i) speed <= 16'h0013;
      wait_bit(BRK, 1'b0, n);
      chk("energized at close", 1, motor_energize_o);
      wait_bit(ENG, 1'b0, n);
      chk("closing cycles", TICK + 1, n);
      chk("brake shut", 0, brake_open);
      @(posedge core_clk_i) cmd <= '0;
   endtask : stop_cycle

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      #(100 * 60000);
      bad_count++;
      give_verdict();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1 chk("limiter after reset", 1, ovlim_enable_o);
      for (int i = 0; i < CFG_N; i++) begin
         rd(i[3:0], CFG_RESET[i], "config reset");
      end
      rd(4'h9, 16'h0000, "unmapped read");
      // low braking power: limiter off, ramp lengthened, chopper live
      wr(REG_POWER, 16'h0005);
      wait_bit(7, 1'b1, n);
      chk("limiter with power", 0, ovlim_enable_o);
      chk("ramp extend", 1, ramp_extend_o);
      @(posedge core_clk_i) dclink <= 16'h0320;
      wait_bit(CHP, 1'b1, n);
      chk("chopper on delay", 1, 16'(n <= 3));
      @(posedge core_clk_i) dclink <= 16'h030d;
      repeat (4) @(posedge core_clk_i);
      #1 chk("chopper hysteresis", 1, chopper_on_o);
      @(posedge core_clk_i) dclink <= 16'h030b;
      wait_bit(CHP, 1'b0, n);
      wr(REG_POWER, 16'h000a);
      @(posedge core_clk_i);
      #1 chk("ramp extend at limit", 0, ramp_extend_o);
      wr(REG_POWER, 16'h0000);
      repeat (3) @(posedge core_clk_i);
      #1 chk("limiter back", 1, ovlim_enable_o);
      // brake disabled: switch-on runs without any release
      wr(REG_MAG, 16'h0002);
      wr(REG_OPEN, 16'h0001);
      wr(REG_CLOSE, 16'h0001);
      wr(REG_OUT0_SEL, SRC_BRAKE_RELEASE);
      @(posedge core_clk_i) cmd.switch_on <= 1'b1;
      wait_bit(ACC, 1'b1, n);
      chk("brake while disabled", 0, brake_release_o);
      @(posedge core_clk_i) cmd <= 4'b0001;
      wait_bit(ENG, 1'b0, n);
      @(posedge core_clk_i) cmd <= '0;
      wr(REG_CTRL, 16'h0001);
      stop_cycle(1'b0);
      stop_cycle(1'b1);
      // coast in run with speed left at 19 rpm, then coast through an input contact
      wr(REG_OUT1_SEL, SRC_BRAKE_RELEASE);
      @(posedge core_clk_i) cmd.switch_on <= 1'b1;
      wait_bit(ACC, 1'b1, n);
      chk("both outputs", 2'b11, dig_out_o);
      rd(REG_STATUS, {12'h003, 1'b0, ST_RUN}, "status in run");
      @(posedge core_clk_i) cmd.coast_stop <= 1'b1;
      wait_bit(BRK, 1'b0, n);
      chk("coast delay", 1, 16'(n <= 3));
      chk("coast energize", 0, motor_energize_o);
      @(posedge core_clk_i) cmd <= '0;
      wr(REG_COAST_SEL, {COAST_GRP_DIGIN, 4'h3});
      @(posedge core_clk_i) cmd.switch_on <= 1'b1;
      wait_bit(ACC, 1'b1, n);
      @(posedge core_clk_i) dig_in[3] <= 1'b0;
      wait_bit(BRK, 1'b0, n);
      chk("input coast delay", 1, 16'(n <= 3));
      give_verdict();
   end
endmodule : motor_brake_sequencer_tb
